// ### design/pmseq_sync.sv
// two-flop synchroniser bank
`timescale 1ns/10ps
module pmseq_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_ff;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			meta_ff <= '0;
			q <= '0;
		end else begin
			meta_ff <= d;
			q <= meta_ff;
		end
	end
endmodule : pmseq_sync

// ### design/pmseq_top.sv
// power sequencer core: order, protection, rails-valid
`timescale 1ns/10ps
`include "pmseq_cfg.svh"
module pmseq_top #(
	parameter int CAL_CYC = `PMSEQ_CAL_CYC,
	parameter int STEP_CYC = `PMSEQ_STEP_CYC,
	parameter int SURGE_CYC = `PMSEQ_SURGE_CYC,
	parameter int VALID_CYC = `PMSEQ_VALID_CYC
) (
	// clock and reset (reset = analog rail loss)
	input wire logic clk,
	input wire logic nrst,
	// pins
	input wire logic chip_on_request,
	input wire logic main_input_supply_ok,
	input wire logic [`PMSEQ_NCH-1:0] order_select_pin,
	// analog detectors
	input wire logic thermal_trip,
	input wire logic input_surge_guard,
	input wire logic [`PMSEQ_NCH-1:0] channel_good,
	// host register write port
	input wire logic host_wr,
	input wire logic host_next_order_wr,
	input wire logic [`PMSEQ_ORDER_W-1:0] host_next_order,
	input wire logic host_thermal_hiccup,
	input wire logic host_surge_hiccup,
	// outputs
	output pmseq_pkg::pmseq_state_t state,
	output logic [`PMSEQ_NCH-1:0] channel_en,
	output logic host_wr_accept,
	output logic rails_valid_output_o,
	output logic rails_valid_output_oe
);
	import pmseq_pkg::*;

	// chip-on, supply-ok and thermal flags share one synchroniser bank
	localparam int SW = 3;
	logic [SW-1:0] raw, syn;
	logic en_s, vin_s, hot_s, surge_s;
	logic [`PMSEQ_NCH-1:0] good_s;
	logic [`PMSEQ_ORDER_W-1:0] order_ff;
	logic thiccup_ff, shiccup_ff, latched_ff, en_d_ff;
	logic [`PMSEQ_CNT_W-1:0] cnt_ff, surge_cnt_ff, pg_cnt_ff;
	pmseq_idx_t step_ff;
	pmseq_state_t nxt_state;

	// ========================================
	// input synchronisers
	assign raw = {chip_on_request, main_input_supply_ok, thermal_trip};
	pmseq_sync #(.W(SW)) u_sync (.clk(clk), .nrst(nrst), .d(raw), .q(syn));
	pmseq_sync #(.W(`PMSEQ_NCH)) u_sync_g (.clk(clk), .nrst(nrst), .d(channel_good),
		.q(good_s));
	pmseq_sync #(.W(1)) u_sync_s (.clk(clk), .nrst(nrst), .d(input_surge_guard),
		.q(surge_s));
	assign en_s = syn[SW-1];
	assign vin_s = syn[SW-2];
	assign hot_s = syn[SW-3];

	// position p of the order holds the channel index (3 bits each)
	function automatic pmseq_idx_t ch_at(input logic [`PMSEQ_ORDER_W-1:0] o,
		input pmseq_idx_t p);
		ch_at = o[p*3 +: 3];
	endfunction : ch_at

	// ========================================
	// host settings; reset comes only from analog rail loss
	assign host_wr_accept = host_wr & vin_s & (state != PMSEQ_CAL);
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			order_ff <= `PMSEQ_ORDER_DEF;
			thiccup_ff <= 1'b0;
			shiccup_ff <= 1'b0;
		end else if (host_wr_accept) begin
			if (host_next_order_wr)
				order_ff <= host_next_order;
			thiccup_ff <= host_thermal_hiccup;
			shiccup_ff <= host_surge_hiccup;
		end
	end

	// ========================================
	// surge delay: channels drop only after the surge persists 5ms
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			surge_cnt_ff <= '0;
		else if (!surge_s)
			surge_cnt_ff <= '0;
		else if (surge_cnt_ff != SURGE_CYC[`PMSEQ_CNT_W-1:0])
			surge_cnt_ff <= surge_cnt_ff + 1'b1;
	end
	wire surge_trip = surge_s && (surge_cnt_ff == SURGE_CYC[`PMSEQ_CNT_W-1:0]);
	wire fault = hot_s | surge_trip;

	// ========================================
	// latch-off without hiccup, cleared by a chip-on low-high cycle
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			en_d_ff <= 1'b0;
		else
			en_d_ff <= en_s;
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			latched_ff <= 1'b0;
		else if ((hot_s && !thiccup_ff) || (surge_trip && !shiccup_ff))
			latched_ff <= 1'b1;
		else if (en_s && !en_d_ff)
			latched_ff <= 1'b0;
	end

	// ========================================
	// sequencer
	always_comb begin
		nxt_state = state;
		unique case (state)
			PMSEQ_OFF: if (en_s && vin_s && !fault && !latched_ff) nxt_state = PMSEQ_CAL;
			PMSEQ_CAL: if (cnt_ff == CAL_CYC[`PMSEQ_CNT_W-1:0]) nxt_state = PMSEQ_UP;
			PMSEQ_UP: if (step_ff == pmseq_idx_t'(`PMSEQ_NCH)) nxt_state = PMSEQ_RUN;
			PMSEQ_RUN: ;
			PMSEQ_DOWN: if (step_ff == 3'h0) nxt_state = PMSEQ_OFF;
			PMSEQ_FAULT: nxt_state = PMSEQ_OFF;
			default: nxt_state = PMSEQ_OFF;
		endcase
		if (fault && state != PMSEQ_OFF)
			nxt_state = PMSEQ_FAULT;
		else if (!en_s && state inside {PMSEQ_CAL, PMSEQ_UP, PMSEQ_RUN})
			nxt_state = PMSEQ_DOWN;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			state <= PMSEQ_OFF;
		else
			state <= nxt_state;
	end

	// step counter and position
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_ff <= '0;
			step_ff <= '0;
		end else if (state != nxt_state) begin
			cnt_ff <= '0;
		end else if (state == PMSEQ_UP || state == PMSEQ_DOWN) begin
			if (cnt_ff == STEP_CYC[`PMSEQ_CNT_W-1:0]) begin
				cnt_ff <= '0;
				if (state == PMSEQ_UP)
					step_ff <= step_ff + 3'h1;
				else
					step_ff <= step_ff - 3'h1;
			end else
				cnt_ff <= cnt_ff + 1'b1;
		end else if (state == PMSEQ_CAL) begin
			cnt_ff <= cnt_ff + 1'b1;
			step_ff <= '0;
		end else if (state == PMSEQ_FAULT) begin
			step_ff <= '0;
		end
	end

	// channel enables from order and step position
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			channel_en <= '0;
		else if (nxt_state == PMSEQ_FAULT || nxt_state == PMSEQ_OFF)
			channel_en <= '0;
		else
			for (int p = 0; p < `PMSEQ_NCH; p++)
				channel_en[ch_at(order_ff, pmseq_idx_t'(p))] <= (pmseq_idx_t'(p) < step_ff);
	end

	// ========================================
	// rails-valid delay and open-drain drive
	wire last_good = (state == PMSEQ_RUN) && good_s[ch_at(order_ff, 3'h4)];
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			pg_cnt_ff <= '0;
		else if (!last_good)
			pg_cnt_ff <= '0;
		else if (pg_cnt_ff != VALID_CYC[`PMSEQ_CNT_W-1:0])
			pg_cnt_ff <= pg_cnt_ff + 1'b1;
	end
	// released high by the pull-up; driven low otherwise
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			rails_valid_output_oe <= 1'b1;
		else
			rails_valid_output_oe <= !(last_good && !fault && en_s &&
				(pg_cnt_ff == VALID_CYC[`PMSEQ_CNT_W-1:0]));
	end
	assign rails_valid_output_o = 1'b0;
endmodule : pmseq_top

// ### shared/pmseq_cfg.svh
// constants of the power sequencer
`ifndef PMSEQ_CFG_SVH
`define PMSEQ_CFG_SVH

`define PMSEQ_CLK_MHZ 200
`define PMSEQ_CAL_US 500
`define PMSEQ_CAL_CYC (`PMSEQ_CAL_US * `PMSEQ_CLK_MHZ)
`define PMSEQ_SURGE_MS 5
`define PMSEQ_SURGE_CYC (`PMSEQ_SURGE_MS * 1000 * `PMSEQ_CLK_MHZ)
`define PMSEQ_VALID_MS 5
`define PMSEQ_VALID_CYC (`PMSEQ_VALID_MS * 1000 * `PMSEQ_CLK_MHZ)
`define PMSEQ_STEP_US 100
`define PMSEQ_STEP_CYC (`PMSEQ_STEP_US * `PMSEQ_CLK_MHZ)
`define PMSEQ_NCH 5
`define PMSEQ_CNT_W 24
`define PMSEQ_ORDER_W 15
`define PMSEQ_ORDER_DEF 15'h4688

`endif

// ### shared/pmseq_pkg.sv
// types of the power sequencer
package pmseq_pkg;
	typedef enum logic [2:0] {
		PMSEQ_OFF = 3'b000,
		PMSEQ_CAL = 3'b001,
		PMSEQ_UP = 3'b011,
		PMSEQ_RUN = 3'b010,
		PMSEQ_DOWN = 3'b110,
		PMSEQ_FAULT = 3'b111
	} pmseq_state_t;
	typedef logic [2:0] pmseq_idx_t;
endpackage : pmseq_pkg

// ### verif/pmseq_chk_assertions.sv
// assertions on the ports of the power sequencer
`timescale 1ns/10ps
`include "pmseq_cfg.svh"
module pmseq_chk #(
	parameter int SURGE_CYC = 20,
	parameter int VALID_CYC = 20
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// inputs
	input wire logic chip_on_request,
	input wire logic main_input_supply_ok,
	input wire logic thermal_trip,
	input wire logic input_surge_guard,
	input wire logic [`PMSEQ_NCH-1:0] channel_good,
	// outputs
	input wire pmseq_pkg::pmseq_state_t state,
	input wire logic [`PMSEQ_NCH-1:0] channel_en,
	input wire logic host_wr_accept,
	input wire logic rails_valid_output_oe
);
	import pmseq_pkg::*;
	logic [15:0] good_ff;
	logic [15:0] surge_ff;
	// run lengths; 16 bits is ample for the short sim counts
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			good_ff <= 16'h0000;
			surge_ff <= 16'h0000;
		end else begin
			good_ff <= (&channel_good) ? good_ff + 16'h0001 : 16'h0000;
			surge_ff <= input_surge_guard ? surge_ff + 16'h0001 : 16'h0000;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	cal_block_a: assert property (state == PMSEQ_CAL |-> !host_wr_accept)
		else $error("write taken in calibration");
	supply_block_a: assert property (!main_input_supply_ok [*3] |-> !host_wr_accept)
		else $error("write taken without supply");
	hot_off_a: assert property (thermal_trip [*6] |-> channel_en == '0)
		else $error("channels on while hot");
	surge_off_a: assert property (surge_ff > SURGE_CYC + 4 |-> channel_en == '0)
		else $error("channels on after surge delay");
	valid_delay_a: assert property ($fell(rails_valid_output_oe) |-> good_ff >= VALID_CYC)
		else $error("valid released early");
	valid_off_a: assert property (!chip_on_request [*4] |-> rails_valid_output_oe)
		else $error("valid high while off");
	valid_hot_a: assert property (thermal_trip [*4] |-> rails_valid_output_oe)
		else $error("valid high while hot");
	// a fault drops every channel at once, so it is the one exception
	one_step_a: assert property (state inside {PMSEQ_UP, PMSEQ_DOWN}
		|=> state == PMSEQ_FAULT || $onehot0(channel_en ^ $past(channel_en)))
		else $error("several channels at once");
	no_rise_a: assert property (!chip_on_request [*4]
		|=> (channel_en & ~$past(channel_en)) == '0) else $error("channel rose while off");
endmodule : pmseq_chk
bind pmseq_top pmseq_chk #(.SURGE_CYC(SURGE_CYC), .VALID_CYC(VALID_CYC)) u_chk (.clk, .nrst,
	.chip_on_request, .main_input_supply_ok, .thermal_trip, .input_surge_guard, .channel_good,
	.state, .channel_en, .host_wr_accept, .rails_valid_output_oe);

// ### verif/pmseq_rails.sv
// model of the regulator channels and the rails-valid pull-up
`timescale 1ns/10ps
module pmseq_rails (
	// clock
	input wire logic clk,
	// channels
	input wire logic [4:0] en,
	output logic [4:0] good,
	// open-drain pin
	input wire logic pg_o,
	input wire logic pg_oe,
	output logic pg
);
	logic [4:0] rise_ff;
	// a rail needs a cycle to come up but collapses at once
	always_ff @(posedge clk) begin
		rise_ff <= en;
	end
	assign good = rise_ff & en;
	assign pg = pg_oe ? pg_o : 1'b1;
endmodule : pmseq_rails

// ### verif/pmseq_top_test.sv
// self-checking bench of the power sequencer
`timescale 1ns/10ps
module pmseq_top_test;
	import pmseq_pkg::*;
	logic clk, nrst, on, ok, th, su, wr, owr, hth, hsu, acc, pg_o, pg_oe, pg;
	logic [4:0] sel, good, en;
	logic [14:0] ord;
	pmseq_state_t state;
	int err_count, check_count, r;
	pmseq_top #(.CAL_CYC(20), .STEP_CYC(4), .SURGE_CYC(20), .VALID_CYC(20)) u_dut (.clk, .nrst,
		.chip_on_request(on), .main_input_supply_ok(ok), .order_select_pin(sel),
		.thermal_trip(th), .input_surge_guard(su), .channel_good(good), .host_wr(wr),
		.host_next_order_wr(owr), .host_next_order(ord), .host_thermal_hiccup(hth),
		.host_surge_hiccup(hsu), .state, .channel_en(en), .host_wr_accept(acc),
		.rails_valid_output_o(pg_o), .rails_valid_output_oe(pg_oe));
	pmseq_rails u_rails (.clk, .en, .good, .pg_o, .pg_oe, .pg);
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic chk(string n, logic [14:0] e, logic [14:0] g);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic cyc(int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	task automatic till(pmseq_state_t s);
		for (int i = 0; i < 300 && state !== s; i++) @(negedge clk);
		chk("state", 15'(s), 15'(state));
	endtask : till
	task automatic hw(logic [14:0] o, logic t, logic s, logic e);
		{wr, owr, ord, hth, hsu} = {2'b11, o, t, s};
		#1 chk("accept", 15'(e), 15'(acc));
		@(negedge clk);
		{wr, owr} = 2'b00;
	endtask : hw
	function automatic logic [14:0] rot(int k);
		rot = '0;
		for (int i = 0; i < 5; i++) rot[3*i +: 3] = 3'((i + k) % 5);
	endfunction : rot
	task automatic up(int f);
		on = 1'b1;
		for (int i = 0; i < 300 && en === 5'h00; i++) @(negedge clk);
		chk("first", 15'(5'h01 << f), 15'(en));
		till(PMSEQ_RUN);
		chk("all on", 15'h001F, 15'(en));
		for (int i = 0; i < 80 && pg !== 1'b1; i++) @(negedge clk);
		chk("valid", 15'h0001, 15'(pg));
		chk("drive", 15'h0000, 15'(pg_o));
	endtask : up
	task automatic finish_test;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : finish_test
	initial begin
		#100000;
		err_count++;
		finish_test;
	end
	initial begin
		{nrst, on, ok, th, su, wr, owr, hth, hsu} = 9'h040;
		ord = 15'h0000;
		r = $urandom(65487);
		sel = 5'($urandom);
		cyc(3);
		nrst = 1'b1;
		chk("reset en", 15'h0000, 15'(en));
		on = 1'b1;
		till(PMSEQ_CAL);
		hw(rot(1), 1'b1, 1'b1, 1'b0);
		up(0);
		hw(rot(2), 1'b1, 1'b1, 1'b1);
		on = 1'b0;
		cyc(4);
		chk("valid off", 15'h0000, 15'(pg));
		till(PMSEQ_OFF);
		up(2);
		th = 1'b1;
		cyc(8);
		chk("hot off", 15'h0000, 15'(en));
		th = 1'b0;
		up(2);
		su = 1'b1;
		cyc(15);
		chk("surge wait", 15'h001F, 15'(en));
		cyc(15);
		chk("surge off", 15'h0000, 15'(en));
		su = 1'b0;
		up(2);
		for (int k = 0; k < 2; k++) begin
			r = $urandom_range(4);
			hw(rot(r), 1'b0, 1'b0, 1'b1);
			{th, su} = k ? 2'b01 : 2'b10;
			cyc(30);
			{th, su} = 2'b00;
			cyc(40);
			chk("latched", 15'h0000, 15'(en));
			on = 1'b0;
			cyc(5);
			up(r);
		end
		ok = 1'b0;
		cyc(3);
		hw(rot(3), 1'b1, 1'b1, 1'b0);
		{nrst, on, ok} = 3'b001;
		cyc(3);
		nrst = 1'b1;
		cyc(3);
		up(0);
		finish_test;
	end
endmodule : pmseq_top_test
